/* rtl/cpsi_top.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "cpsi_defs.svh"

module cpsi_top
#(
  parameter int ADDR_W = 12  // axi address width
)
(
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]        s_axi_awaddr_in,
  input  wire logic                     s_axi_awvalid_in,
  output logic                          s_axi_awready_out,
  // axi4-lite write data
  input  wire logic [31:0]              s_axi_wdata_in,
  input  wire logic [3:0]               s_axi_wstrb_in,
  input  wire logic                     s_axi_wvalid_in,
  output logic                          s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]                    s_axi_bresp_out,
  output logic                          s_axi_bvalid_out,
  input  wire logic                     s_axi_bready_in,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]        s_axi_araddr_in,
  input  wire logic                     s_axi_arvalid_in,
  output logic                          s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0]                   s_axi_rdata_out,
  output logic [1:0]                    s_axi_rresp_out,
  output logic                          s_axi_rvalid_out,
  input  wire logic                     s_axi_rready_in,
  // authentication core side
  input  wire cpsi_pkg::cpsi_events_t   events_in,
  output cpsi_pkg::cpsi_core_ctrl_t     core_ctrl_out,
  // interrupt to the controller
  output logic                          irq_out
);

  // ------------------------------------------------------------------
  // axi write channel state
  // ------------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_q;   // captured write address
  logic              aw_full_q;   // write address held
  logic [31:0]       w_data_q;    // captured write data
  logic [3:0]        w_strb_q;    // captured byte enables
  logic              w_full_q;    // write data held
  logic              bvalid_q;    // write response pending
  logic [1:0]        bresp_q;     // write response code

  // ------------------------------------------------------------------
  // axi read channel state
  // ------------------------------------------------------------------
  logic              rvalid_q;    // read data pending
  logic [31:0]       rdata_q;     // read data word
  logic [1:0]        rresp_q;     // read response code

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [7:0] enable_q;           // interrupt_enable
  logic [7:0] irq_stat_q;         // sticky interrupt status, bits 7..1
  logic [1:0] config_q;           // wait-lock and repeater mode
  logic       rx_detect_q;        // status bit 3
  logic       list_ready_q;       // status bit 2
  logic       key_ready_q;        // status bit 1
  logic       authenticated_q;    // status bit 0
  logic       found_prev_q;       // last receiver-found condition
  logic       restart_q;          // restart strobe to the core
  logic       irq_q;              // registered interrupt output

  // ------------------------------------------------------------------
  // handshakes and decode
  // ------------------------------------------------------------------
  wire logic aw_take = s_axi_awvalid_in & s_axi_awready_out;
  wire logic w_take  = s_axi_wvalid_in & s_axi_wready_out;
  wire logic ar_take = s_axi_arvalid_in & s_axi_arready_out;

  // both halves of a write present; performed on this edge
  wire logic do_write = aw_full_q & w_full_q & ~bvalid_q;

  // only the low byte lane carries register data
  wire logic lane0 = w_strb_q[0];

  wire logic [9:0] wr_idx = aw_addr_q[11:2];       // write word index
  wire logic [9:0] rd_idx = s_axi_araddr_in[11:2]; // read word index

  wire logic wr_cfg  = (wr_idx == `CPSI_IDX_CONFIG);
  wire logic wr_ctl  = (wr_idx == `CPSI_IDX_CONTROL);
  wire logic wr_sts  = (wr_idx == `CPSI_IDX_STATUS);
  wire logic wr_ena  = (wr_idx == `CPSI_IDX_ENABLE);
  wire logic wr_isr  = (wr_idx == `CPSI_IDX_IRQ_STAT);
  // status is read only but a write to it is still a valid address
  wire logic wr_hit  = wr_cfg | wr_ctl | wr_sts | wr_ena | wr_isr;

  wire logic rd_cfg  = (rd_idx == `CPSI_IDX_CONFIG);
  wire logic rd_ctl  = (rd_idx == `CPSI_IDX_CONTROL);
  wire logic rd_sts  = (rd_idx == `CPSI_IDX_STATUS);
  wire logic rd_ena  = (rd_idx == `CPSI_IDX_ENABLE);
  wire logic rd_isr  = (rd_idx == `CPSI_IDX_IRQ_STAT);
  wire logic rd_hit  = rd_cfg | rd_ctl | rd_sts | rd_ena | rd_isr;

  // write strobes, one cycle each
  wire logic we_cfg  = do_write & lane0 & wr_cfg;
  wire logic we_ctl  = do_write & lane0 & wr_ctl;
  wire logic we_ena  = do_write & lane0 & wr_ena;
  wire logic we_isr  = do_write & lane0 & wr_isr;

  // confirmation and restart strobes from protection_control
  wire logic list_confirm =
    we_ctl & w_data_q[`CPSI_CTL_LIST_CONFIRM];
  wire logic key_confirm =
    we_ctl & w_data_q[`CPSI_CTL_KEY_CONFIRM];
  wire logic restart_req =
    we_ctl & w_data_q[`CPSI_CTL_RESTART];

  // ------------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------------
  wire logic wait_lock = config_q[`CPSI_CFG_WAIT_LOCK];
  wire logic repeater  = config_q[`CPSI_CFG_REPEATER];

  // with wait-lock set, detection only counts once lock is seen too
  wire logic found_cond = events_in.receiver_detected &
    (~wait_lock | events_in.receiver_locked);
  wire logic found_evt = found_cond & ~found_prev_q;

  // event vector in interrupt status layout; bit 0 is not sticky
  wire logic [7:0] irq_set = {
    events_in.indirect_done,
    found_evt,
    ~events_in.downstream_irq_n,
    events_in.key_list_loaded,
    events_in.receiver_key_loaded,
    events_in.auth_lost,
    events_in.auth_pass,
    1'b0
  };

  // write one to clear; bit 0 is computed, never stored
  wire logic [7:0] irq_clr = we_isr ? {w_data_q[7:1], 1'b0} : 8'h00;

  // set wins over a clear landing in the same cycle
  wire logic [7:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

  // any individually enabled event currently indicated
  wire logic pending =
    |(irq_stat_q[7:1] & enable_q[7:1]);

  // global gate then pending drives the line
  wire logic irq_d = enable_q[`CPSI_IRQ_GLOBAL] & pending;

  // ------------------------------------------------------------------
  // status flag next values; set wins over same-cycle clear
  // ------------------------------------------------------------------
  wire logic list_ready_d =
    (list_ready_q & ~list_confirm)
    | events_in.key_list_loaded;
  wire logic key_ready_d =
    (key_ready_q & ~key_confirm)
    | events_in.receiver_key_loaded;
  // a pass that arrives together with a restart still counts
  wire logic authenticated_d =
    (authenticated_q & ~events_in.auth_lost & ~restart_req)
    | events_in.auth_pass;

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  wire logic [7:0] status_byte = {
    4'h0, rx_detect_q, list_ready_q, key_ready_q, authenticated_q
  };
  wire logic [7:0] isr_byte = {irq_stat_q[7:1], pending};
  wire logic [7:0] cfg_byte = {6'h00, config_q};

  // control strobes self clear, so the register reads as zero
  wire logic [31:0] rd_word =
    rd_sts ? {24'h000000, status_byte} :
    rd_ena ? {24'h000000, enable_q}    :
    rd_isr ? {24'h000000, isr_byte}    :
    rd_cfg ? {24'h000000, cfg_byte}    :
    `CPSI_RST_WORD;

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // a new address is refused while a response waits, so at most
  // one write is ever in flight
  assign s_axi_awready_out = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready_out  = ~w_full_q & ~bvalid_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = ~rvalid_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;

  // repeaters run on through key-ready; the list hold always applies
  assign core_ctrl_out.auth_hold =
    list_ready_q
    | (key_ready_q & ~repeater);
  assign core_ctrl_out.restart_pulse = restart_q;
  assign irq_out = irq_q;

  // ------------------------------------------------------------------
  // write address capture
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (aw_take)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr_in;
    end
    else if (do_write)
      aw_full_q <= 1'b0;
  end

  // ------------------------------------------------------------------
  // write data capture
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      w_full_q <= 1'b0;
      w_data_q <= `CPSI_RST_WORD;
      w_strb_q <= 4'h0;
    end
    else if (w_take)
    begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata_in;
      w_strb_q <= s_axi_wstrb_in;
    end
    else if (do_write)
      w_full_q <= 1'b0;
  end

  // ------------------------------------------------------------------
  // write response
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `CPSI_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      // unmapped addresses answer slverr and change nothing
      bresp_q  <= wr_hit ? `CPSI_RESP_OKAY : `CPSI_RESP_SLVERR;
    end
    else if (s_axi_bready_in)
      bvalid_q <= 1'b0;
  end

  // ------------------------------------------------------------------
  // read response; data captured when the address is taken
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= `CPSI_RST_WORD;
      rresp_q  <= `CPSI_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? `CPSI_RESP_OKAY : `CPSI_RESP_SLVERR;
    end
    else if (s_axi_rready_in)
      rvalid_q <= 1'b0;
  end

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      enable_q <= `CPSI_RST_BYTE;
      config_q <= 2'b00;
    end
    else
    begin
      if (we_ena)
        enable_q <= w_data_q[7:0];
      if (we_cfg)
        config_q <= w_data_q[1:0];
    end
  end

  // ------------------------------------------------------------------
  // protection status flags
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rx_detect_q  <= 1'b0;
      list_ready_q <= 1'b0;
      key_ready_q  <= 1'b0;
      authenticated_q <= 1'b0;
    end
    else
    begin
      rx_detect_q  <= events_in.receiver_detected;
      list_ready_q <= list_ready_d;
      key_ready_q  <= key_ready_d;
      authenticated_q <= authenticated_d;
    end
  end

  // ------------------------------------------------------------------
  // interrupt status, found edge history, restart strobe, line
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      irq_stat_q   <= `CPSI_RST_BYTE;
      found_prev_q <= 1'b0;
      restart_q    <= 1'b0;
      irq_q        <= 1'b0;
    end
    else
    begin
      irq_stat_q   <= irq_stat_d;
      found_prev_q <= found_cond;
      restart_q    <= restart_req;
      irq_q        <= irq_d;
    end
  end

endmodule

`default_nettype wire

/* inc/cpsi_defs.svh */
`ifndef CPSI_DEFS_SVH
`define CPSI_DEFS_SVH

// register indices; byte address is four times the index
`define CPSI_IDX_CONFIG   10'h0c2
`define CPSI_IDX_CONTROL  10'h0c3
`define CPSI_IDX_STATUS   10'h0c4
`define CPSI_IDX_ENABLE   10'h0c6
`define CPSI_IDX_IRQ_STAT 10'h0c7

// protection_status bit positions
`define CPSI_STS_RX_DETECT  3
`define CPSI_STS_LIST_READY 2
`define CPSI_STS_KEY_READY  1
`define CPSI_STS_AUTHENTICATED 0

// interrupt_enable / interrupt status bit positions
`define CPSI_IRQ_INDIRECT   7
`define CPSI_IRQ_RX_FOUND   6
`define CPSI_IRQ_DOWNSTREAM 5
`define CPSI_IRQ_LIST_READY 4
`define CPSI_IRQ_KEY_READY  3
`define CPSI_IRQ_AUTH_FAIL  2
`define CPSI_IRQ_AUTH_PASS  1
`define CPSI_IRQ_GLOBAL     0

// protection_control strobe bits (self clearing)
`define CPSI_CTL_LIST_CONFIRM 5
`define CPSI_CTL_KEY_CONFIRM  4
`define CPSI_CTL_RESTART      0

// configuration bits
`define CPSI_CFG_WAIT_LOCK 0
`define CPSI_CFG_REPEATER  1

// reset values
`define CPSI_RST_BYTE 8'h00
`define CPSI_RST_WORD 32'h0000_0000

// axi response codes
`define CPSI_RESP_OKAY   2'b00
`define CPSI_RESP_SLVERR 2'b10

`endif

/* inc/cpsi_pkg.sv */
`default_nettype none

package cpsi_pkg;

  // event and level inputs from the authentication core
  typedef struct packed {
    logic indirect_done;       // pulse: indirect register access finished
    logic receiver_detected;   // level: downstream receiver present
    logic receiver_locked;     // level: receiver locked to serial data
    logic downstream_irq_n;    // level, active low: receiver interrupt
    logic key_list_loaded;     // pulse: key list now in key_list_fifo
    logic receiver_key_loaded; // pulse: key now in receiver_key_regs
    logic auth_pass;           // pulse: authentication completed
    logic auth_lost;           // pulse: authentication failed or lost
  } cpsi_events_t;

  // controls back to the authentication core
  typedef struct packed {
    logic auth_hold;     // level: stall authentication progress
    logic restart_pulse; // pulse: restart authentication
  } cpsi_core_ctrl_t;

endpackage

`default_nettype wire

/* test/cpsi_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module cpsi_top_sva
#(
  parameter int ADDR_W = 12  // same width as the bound block
)
(
  input wire logic                   clk_in,
  input wire logic                   reset_in,
  input wire logic [ADDR_W-1:0]      s_axi_awaddr_in,
  input wire logic                   s_axi_awvalid_in,
  input wire logic                   s_axi_awready_out,
  input wire logic [31:0]            s_axi_wdata_in,
  input wire logic [3:0]             s_axi_wstrb_in,
  input wire logic                   s_axi_wvalid_in,
  input wire logic                   s_axi_wready_out,
  input wire logic [1:0]             s_axi_bresp_out,
  input wire logic                   s_axi_bvalid_out,
  input wire logic                   s_axi_bready_in,
  input wire logic [ADDR_W-1:0]      s_axi_araddr_in,
  input wire logic                   s_axi_arvalid_in,
  input wire logic                   s_axi_arready_out,
  input wire logic [31:0]            s_axi_rdata_out,
  input wire logic [1:0]             s_axi_rresp_out,
  input wire logic                   s_axi_rvalid_out,
  input wire logic                   s_axi_rready_in,
  input wire cpsi_pkg::cpsi_events_t events_in,
  input wire cpsi_pkg::cpsi_core_ctrl_t core_ctrl_out,
  input wire logic                   irq_out
);
  // single clock domain, so one default clock and reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  AST_LIST_HOLD: assert property (
    events_in.key_list_loaded |=> core_ctrl_out.auth_hold)
    else $error("auth hold missing after key list load");
  AST_RESTART_ONE: assert property (
    core_ctrl_out.restart_pulse |=> !core_ctrl_out.restart_pulse)
    else $error("restart pulse longer than one cycle");
  AST_IRQ_RESET: assert property (
    $fell(reset_in) |-> !irq_out)
    else $error("interrupt high straight after reset");
  AST_WRITE_RESP: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response late");
  AST_READ_TURN: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  AST_B_BLOCKS: assert property (
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while response pending");
  AST_AR_BLOCK: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted while data pending");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  AST_RVALID_HOLD: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  AST_UPPER_ZERO: assert property (
    s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule

bind cpsi_top cpsi_top_sva #(.ADDR_W(ADDR_W)) u_sva (
  .clk_in(clk_in), .reset_in(reset_in), .s_axi_awaddr_in(s_axi_awaddr_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .events_in(events_in), .core_ctrl_out(core_ctrl_out), .irq_out(irq_out));

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpsi_defs.svh"

// count every compare, report and count a mismatch at once
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end

module tb_top;
  localparam logic [11:0] A_CFG = {`CPSI_IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_CTL = {`CPSI_IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_STS = {`CPSI_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_EN  = {`CPSI_IDX_ENABLE, 2'b00};
  localparam logic [11:0] A_ISR = {`CPSI_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_BAD = 12'h0f0;  // no register here
  logic        clk_in, reset_in, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  cpsi_pkg::cpsi_events_t   ev;   // event stimulus
  cpsi_pkg::cpsi_core_ctrl_t ctl; // core controls observed
  int          err_count, cmp_count;
  int          restarts = 0;  // restart pulses seen on the core side

  // count restart pulses as the core would see them
  always @(posedge clk_in)
    if (ctl.restart_pulse === 1'b1) restarts <= restarts + 1;

  cpsi_top #(.ADDR_W(12)) uut (
    .clk_in(clk_in), .reset_in(reset_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .events_in(ev), .core_ctrl_out(ctl),
    .irq_out(irq));

  // status after an event, from the flag rules
  function automatic logic [3:0] st_after(logic [3:0] s, int b);
    case (b)
      6: return s | 4'h8;
      4: return s | 4'h4;
      3: return s | 4'h2;
      2: return s & 4'he;
      1: return s | 4'h1;
      default: return s;
    endcase
  endfunction

  // sticky bits plus the pending bit, which ignores the global gate
  function automatic logic [31:0] isr_exp(logic [7:0] m, logic [7:0] en);
    return {24'h0, m[7:1], |(m[7:1] & en[7:1])};
  endfunction

  // write: both halves offered together, response taken late on purpose
  task automatic wrc(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk_in);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ta && tw))
    begin
      @(negedge clk_in);
      if (awvalid && awready) ta = 1'b1;
      if (wvalid && wready) tw = 1'b1;
      @(posedge clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge clk_in); while (!bvalid);
    @(posedge clk_in);
    bready <= 1'b1;
    @(negedge clk_in);
    `CHK(bresp, er)
    @(posedge clk_in);
    bready <= 1'b0;
  endtask

  // read and compare; ready raised only once data is shown
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(negedge clk_in); while (!arready);
    @(posedge clk_in);
    arvalid <= 1'b0;
    do @(negedge clk_in); while (!rvalid);
    @(posedge clk_in);
    rready <= 1'b1;
    @(negedge clk_in);
    `CHK(rdata, e)
    `CHK(rresp, er)
    @(posedge clk_in);
    rready <= 1'b0;
  endtask

  // one event for interrupt bit b; detected and locked levels stay as they are, downstream_irq_n returns high
  task automatic fire(input int b);
    @(posedge clk_in);
    case (b)
      7: ev.indirect_done <= 1'b1;
      6: ev.receiver_detected <= 1'b1;
      5: ev.downstream_irq_n <= 1'b0;
      4: ev.key_list_loaded <= 1'b1;
      3: ev.receiver_key_loaded <= 1'b1;
      2: ev.auth_lost <= 1'b1;
      default: ev.auth_pass <= 1'b1;
    endcase
    @(posedge clk_in);
    ev <= 8'h10 | (ev & 8'h60);
  endtask

  // let the registered interrupt settle, then look mid-cycle
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    `CHK(irq, e)
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // watchdog: the tests need a few hundred cycles at most
  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    end_of_test();
  end

  initial
  begin
    logic [7:0]  en;
    logic [1:0]  cfg;
    logic [3:0]  st;
    logic [31:0] d;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 56'h0;
    ev = 8'h10;
    reset_in = 1'b1;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(32'hca445e12));
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    // reset values, access kinds, unmapped place
    rdc(A_EN, 32'h0, `CPSI_RESP_OKAY);
    rdc(A_STS, 32'h0, `CPSI_RESP_OKAY);
    rdc(A_ISR, 32'h0, `CPSI_RESP_OKAY);
    rdc(A_CFG, 32'h0, `CPSI_RESP_OKAY);
    d = $urandom;
    wrc(A_EN, d, `CPSI_RESP_OKAY);
    rdc(A_EN, {24'h0, d[7:0]}, `CPSI_RESP_OKAY);
    wrc(A_BAD, 32'hffff_ffff, `CPSI_RESP_SLVERR);
    rdc(A_BAD, 32'h0, `CPSI_RESP_SLVERR);
    irq_is(1'b0);
    $display("test registers done");
    // each event alone; round 0 has the global gate off
    st = 4'h0;
    for (int k = 0; k < 3; k++)
    begin
      en = (k == 0) ? 8'hfe : ((k == 1) ? 8'hff : 8'($urandom));
      // both repeater settings are certain to be seen
      cfg = (k == 0) ? 2'b00 : ((k == 1) ? 2'b10 : 2'($urandom) & 2'b10);
      wrc(A_CFG, {30'h0, cfg}, `CPSI_RESP_OKAY);
      wrc(A_EN, {24'h0, en}, `CPSI_RESP_OKAY);
      for (int b = 1; b < 8; b++)
      begin
        wrc(A_ISR, 32'h0000_00fe, `CPSI_RESP_OKAY);
        fire(b);
        st = st_after(st, b);
        irq_is(en[0] & en[b]);
        `CHK(ctl.auth_hold, st[2] | (st[1] & ~cfg[1]))
        rdc(A_ISR, isr_exp(8'h01 << b, en), `CPSI_RESP_OKAY);
        rdc(A_STS, {28'h0, st}, `CPSI_RESP_OKAY);
      end
      @(posedge clk_in);
      ev.receiver_detected <= 1'b0;
      fire(1);
      // controller polls authenticated before sending protected video
      rdc(A_STS, 32'h0000_0007, `CPSI_RESP_OKAY);
      wrc(A_CTL, 32'h0000_0031, `CPSI_RESP_OKAY);
      `CHK(restarts, k + 1)
      rdc(A_STS, 32'h0, `CPSI_RESP_OKAY);
      `CHK(ctl.auth_hold, 1'b0)
      rdc(A_CTL, 32'h0, `CPSI_RESP_OKAY);
      wrc(A_ISR, 32'h0000_00fe, `CPSI_RESP_OKAY);
      irq_is(1'b0);
      st = 4'h0;
    end
    $display("test events done");
    // receiver found waits for lock when so configured
    wrc(A_CFG, 32'h1, `CPSI_RESP_OKAY);
    wrc(A_EN, 32'h41, `CPSI_RESP_OKAY);
    wrc(A_ISR, 32'h0000_00fe, `CPSI_RESP_OKAY);
    @(posedge clk_in);
    ev.receiver_detected <= 1'b1;
    irq_is(1'b0);
    rdc(A_ISR, 32'h0, `CPSI_RESP_OKAY);
    @(posedge clk_in);
    ev.receiver_locked <= 1'b1;
    irq_is(1'b1);
    rdc(A_ISR, 32'h41, `CPSI_RESP_OKAY);
    $display("test wait_lock done");
    end_of_test();
  end
endmodule

`default_nettype wire
